// >>> ubk_defines.vh
`ifndef UBK_DEFINES_VH
`define UBK_DEFINES_VH

// Register indices; byte address is four times the index
`define UBK_IDX_ADDR_HI   32'hffff8600
`define UBK_IDX_ADDR_LO   32'hffff8602
`define UBK_IDX_MASK_HI   32'hffff8604
`define UBK_IDX_MASK_LO   32'hffff8606
`define UBK_IDX_CYC_SEL   32'hffff8608
`define UBK_IDX_INT_STAT  32'hffff860a
`define UBK_IDX_INT_MASK  32'hffff860c
`define UBK_IDX_CTRL      32'hffff860e

`define UBK_BA_ADDR_HI    (`UBK_IDX_ADDR_HI << 2)
`define UBK_BA_ADDR_LO    (`UBK_IDX_ADDR_LO << 2)
`define UBK_BA_MASK_HI    (`UBK_IDX_MASK_HI << 2)
`define UBK_BA_MASK_LO    (`UBK_IDX_MASK_LO << 2)
`define UBK_BA_CYC_SEL    (`UBK_IDX_CYC_SEL << 2)
`define UBK_BA_INT_STAT   (`UBK_IDX_INT_STAT << 2)
`define UBK_BA_INT_MASK   (`UBK_IDX_INT_MASK << 2)
`define UBK_BA_CTRL       (`UBK_IDX_CTRL << 2)

`define UBK_REG_RESET     16'h0000

// Cycle select field positions
`define UBK_CYC_WMASK     16'h00ff
`define UBK_CYC_CPU       6
`define UBK_CYC_DMA       7
`define UBK_CYC_FETCH     4
`define UBK_CYC_DATA      5
`define UBK_CYC_READ      2
`define UBK_CYC_WRITE     3
`define UBK_CYC_SZ_HI     1
`define UBK_CYC_SZ_LO     0
`define UBK_SZ_ANY        2'b00

// Own status, mask and control fields
`define UBK_EV_W          2
`define UBK_EV_BREAK      0
`define UBK_EV_OVERRUN    1
`define UBK_CTRL_AFTER    0

`define UBK_BREAK_LEVEL   4'hf
`define UBK_RESP_OKAY     2'b00
`define UBK_RESP_SLVERR   2'b10
`define UBK_DATA_ZERO     32'h00000000

`endif

// >>> ubk_break_unit.v
// Operation
// - Check every CPU, DMA, transfer cycle
// - Qualify address, master, fetch, direction, size
// - CPU fetch break before or after execution; DMA fetch always before
// - Five 16-bit read/write break registers
// - Byte, halfword and longword register access
// - Break address split high and low
// - Power-on reset clears address registers
// - One mask bit per address bit
// - Power-on reset clears mask registers
// - Mask one excludes bit from compare
// - A 00 master, fetch or direction field blocks break
// - Request at level 15, held while masked
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ubk_defines.vh"

module ubk_break_unit (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        bus_valid,
   input  wire [31:0] bus_addr,
   input  wire        bus_from_dma,
   input  wire        bus_fetch,
   input  wire        bus_write,
   input  wire [1:0]  bus_size,
   input  wire        cpu_exec_done,
   input  wire [3:0]  cpu_interrupt_mask_level,
   input  wire        break_ack,
   output reg         break_req,
   output reg  [3:0]  break_level,
   output reg         irq
);

   reg  [15:0]           break_address_high;
   reg  [15:0]           break_address_low;
   reg  [15:0]           break_address_mask_high;
   reg  [15:0]           break_address_mask_low;
   reg  [15:0]           break_cycle_select;
   reg  [`UBK_EV_W-1:0]  int_status;
   reg  [`UBK_EV_W-1:0]  int_mask;
   reg                   break_after;

   reg                   aw_held;
   reg                   w_held;
   reg  [31:0]           aw_addr_q;
   reg  [15:0]           w_data_q;
   reg  [1:0]            w_strb_q;

   reg                   pending;
   reg                   after_wait;

   wire [31:0]           break_addr;
   wire [31:0]           addr_mask;
   wire                  addr_ok;
   wire                  master_ok;
   wire                  fetch_ok;
   wire                  rw_ok;
   wire                  size_ok;
   wire                  hit;
   wire                  defer;
   wire                  fire;
   wire [15:0]           lane_mask;
   wire                  do_write;

   reg  [31:0]           rd_word;
   reg                   rd_hit;
   reg                   wr_hit;
   reg  [`UBK_EV_W-1:0]  next_status;

   // Break address and mask as full 32-bit words
   assign break_addr = {break_address_high, break_address_low};
   assign addr_mask  = {break_address_mask_high, break_address_mask_low};

   // A set mask bit removes that bit from the compare
   assign addr_ok = ((bus_addr ^ break_addr) & ~addr_mask) == 32'h00000000;

   // A 00 master, fetch or direction field enables neither side, so nothing can match
   assign master_ok = bus_from_dma ? break_cycle_select[`UBK_CYC_DMA]
                                   : break_cycle_select[`UBK_CYC_CPU];
   assign fetch_ok  = bus_fetch    ? break_cycle_select[`UBK_CYC_FETCH]
                                   : break_cycle_select[`UBK_CYC_DATA];
   assign rw_ok     = bus_write    ? break_cycle_select[`UBK_CYC_WRITE]
                                   : break_cycle_select[`UBK_CYC_READ];
   assign size_ok   = (break_cycle_select[`UBK_CYC_SZ_HI:`UBK_CYC_SZ_LO] == `UBK_SZ_ANY)
                   || (break_cycle_select[`UBK_CYC_SZ_HI:`UBK_CYC_SZ_LO] == bus_size);

   assign hit = bus_valid & addr_ok & master_ok & fetch_ok & rw_ok & size_ok;

   // CPU fetch breaks may wait for the instruction to complete
   assign defer = hit & ~bus_from_dma & bus_fetch & break_after;
   assign fire  = (hit & ~defer) | (after_wait & cpu_exec_done);

   assign lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign do_write  = aw_held & w_held & ~s_axi_bvalid;

   // Write address decode
   always @* begin
      case (aw_addr_q)
         `UBK_BA_ADDR_HI:  wr_hit = 1'b1;
         `UBK_BA_ADDR_LO:  wr_hit = 1'b1;
         `UBK_BA_MASK_HI:  wr_hit = 1'b1;
         `UBK_BA_MASK_LO:  wr_hit = 1'b1;
         `UBK_BA_CYC_SEL:  wr_hit = 1'b1;
         `UBK_BA_INT_STAT: wr_hit = 1'b1;
         `UBK_BA_INT_MASK: wr_hit = 1'b1;
         `UBK_BA_CTRL:     wr_hit = 1'b1;
         default:          wr_hit = 1'b0;
      endcase
   end

   // Read mux; narrow registers sit in the low bits
   always @* begin
      rd_word = `UBK_DATA_ZERO;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         `UBK_BA_ADDR_HI:  rd_word[15:0] = break_address_high;
         `UBK_BA_ADDR_LO:  rd_word[15:0] = break_address_low;
         `UBK_BA_MASK_HI:  rd_word[15:0] = break_address_mask_high;
         `UBK_BA_MASK_LO:  rd_word[15:0] = break_address_mask_low;
         `UBK_BA_CYC_SEL:  rd_word[15:0] = break_cycle_select;
         `UBK_BA_INT_STAT: rd_word[`UBK_EV_W-1:0] = int_status;
         `UBK_BA_INT_MASK: rd_word[`UBK_EV_W-1:0] = int_mask;
         `UBK_BA_CTRL:     rd_word[`UBK_CTRL_AFTER] = break_after;
         default:          rd_hit = 1'b0;
      endcase
   end

   // Sticky events; a set in the clearing cycle wins
   always @* begin
      next_status = int_status;
      if (do_write && wr_hit && aw_addr_q == `UBK_BA_INT_STAT) begin
         if (w_strb_q[0]) begin
            next_status = int_status & ~w_data_q[`UBK_EV_W-1:0];
         end
      end
      if (fire) begin
         next_status[`UBK_EV_BREAK] = 1'b1;
         if (pending) begin
            next_status[`UBK_EV_OVERRUN] = 1'b1;
         end
      end
   end

   // Write channel: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `UBK_RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr_q     <= `UBK_DATA_ZERO;
         w_data_q      <= `UBK_REG_RESET;
         w_strb_q      <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data_q     <= s_axi_wdata[15:0];
            w_strb_q     <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `UBK_RESP_OKAY : `UBK_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Only power-on reset reaches these; manual reset has no path in
   always @(posedge aclk) begin
      if (!aresetn) begin
         break_address_high      <= `UBK_REG_RESET;
         break_address_low       <= `UBK_REG_RESET;
         break_address_mask_high <= `UBK_REG_RESET;
         break_address_mask_low  <= `UBK_REG_RESET;
         break_cycle_select      <= `UBK_REG_RESET;
         int_mask                <= {`UBK_EV_W{1'b0}};
         break_after             <= 1'b0;
      end else if (do_write) begin
         case (aw_addr_q)
            `UBK_BA_ADDR_HI: begin
               break_address_high <= (break_address_high & ~lane_mask)
                                   | (w_data_q & lane_mask);
            end
            `UBK_BA_ADDR_LO: begin
               break_address_low <= (break_address_low & ~lane_mask)
                                  | (w_data_q & lane_mask);
            end
            `UBK_BA_MASK_HI: begin
               break_address_mask_high <= (break_address_mask_high & ~lane_mask)
                                        | (w_data_q & lane_mask);
            end
            `UBK_BA_MASK_LO: begin
               break_address_mask_low <= (break_address_mask_low & ~lane_mask)
                                       | (w_data_q & lane_mask);
            end
            `UBK_BA_CYC_SEL: begin
               // Upper byte is reserved and stays zero
               break_cycle_select <= (break_cycle_select & ~lane_mask)
                                   | (w_data_q & lane_mask & `UBK_CYC_WMASK);
            end
            `UBK_BA_INT_MASK: begin
               if (w_strb_q[0]) begin
                  int_mask <= w_data_q[`UBK_EV_W-1:0];
               end
            end
            `UBK_BA_CTRL: begin
               if (w_strb_q[0]) begin
                  break_after <= w_data_q[`UBK_CTRL_AFTER];
               end
            end
            default: begin
               break_after <= break_after;
            end
         endcase
      end
   end

   // Read channel: one-cycle answer
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `UBK_DATA_ZERO;
         s_axi_rresp   <= `UBK_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? `UBK_RESP_OKAY : `UBK_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Break request stays pending until the controller takes it
   always @(posedge aclk) begin
      if (!aresetn) begin
         pending     <= 1'b0;
         after_wait  <= 1'b0;
         break_req   <= 1'b0;
         break_level <= 4'h0;
         int_status  <= {`UBK_EV_W{1'b0}};
         irq         <= 1'b0;
      end else begin
         if (defer) begin
            after_wait <= 1'b1;
         end else if (cpu_exec_done) begin
            after_wait <= 1'b0;
         end
         if (fire) begin
            pending <= 1'b1;
         end else if (break_ack) begin
            pending <= 1'b0;
         end
         // Held while the CPU runs at the top mask level
         break_req   <= pending & (cpu_interrupt_mask_level < `UBK_BREAK_LEVEL);
         break_level <= `UBK_BREAK_LEVEL;
         int_status  <= next_status;
         irq         <= |(next_status & int_mask);
      end
   end

endmodule // ubk_break_unit
`default_nettype wire

// >>> ubk_break_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubk_defines.vh"
module ubk_break_unit_sva (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       bus_valid,
   input wire logic       cpu_exec_done,
   input wire logic [3:0] cpu_interrupt_mask_level,
   input wire logic       break_ack,
   input wire logic       break_req,
   input wire logic [3:0] break_level
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_level; $past(aresetn) |-> break_level == `UBK_BREAK_LEVEL; endproperty
   a_level: assert property (p_level) else $error("break level wrong");
   property p_held; cpu_interrupt_mask_level == 4'hf |=> !break_req; endproperty
   a_held: assert property (p_held) else $error("request while masked");
   property p_rose; $rose(break_req) |-> $past(cpu_interrupt_mask_level) != 4'hf; endproperty
   a_rose: assert property (p_rose) else $error("request rose at level 15");
   property p_ack; break_ack && !bus_valid && !cpu_exec_done ##1 !bus_valid && !cpu_exec_done
      |-> ##1 !break_req; endproperty
   a_ack: assert property (p_ack) else $error("request kept after accept");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
   a_rdone: assert property (p_rdone) else $error("read not closed");
   property p_bref; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_bref: assert property (p_bref) else $error("write taken during response");
   property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
   a_bdone: assert property (p_bdone) else $error("write not closed");
endmodule // ubk_break_unit_sva
`default_nettype wire

// >>> ubk_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module ubk_far_side (
   input  wire logic        aclk,
   input  wire logic        break_req,
   input  wire logic        ack_en,
   output var  logic        bus_valid,
   output var  logic [31:0] bus_addr,
   output var  logic        bus_from_dma,
   output var  logic        bus_fetch,
   output var  logic        bus_write,
   output var  logic [1:0]  bus_size,
   output var  logic        cpu_exec_done,
   output var  logic        break_ack
);
   logic acked = 1'b0;
   initial {bus_valid, bus_addr, bus_from_dma, bus_fetch, bus_write, bus_size} = '0;
   initial {cpu_exec_done, break_ack} = 2'b00;
   // One accept per request; the request lingers a cycle after it
   always @(posedge aclk) begin
      break_ack <= break_req && ack_en && !acked && !break_ack;
      acked <= break_req && (acked || break_ack);
   end
   task cycle(input logic [31:0] a, input logic [4:0] q);
      @(posedge aclk);
      bus_valid <= 1'b1;
      {bus_addr, bus_from_dma, bus_fetch, bus_write, bus_size} <= {a, q};
      @(posedge aclk);
      bus_valid <= 1'b0;
      // Released lines show garbage, not the last cycle
      {bus_addr, bus_from_dma, bus_fetch, bus_write, bus_size} <= ~{a, q};
   endtask
   task exec_done;
      @(posedge aclk);
      cpu_exec_done <= 1'b1;
      @(posedge aclk);
      cpu_exec_done <= 1'b0;
   endtask
endmodule // ubk_far_side
`default_nettype wire

// >>> ubk_break_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubk_defines.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module ubk_break_unit_tb;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, bus_addr;
   logic [3:0]  s_axi_wstrb = 0, cpu_interrupt_mask_level = 0, break_level;
   logic [1:0]  s_axi_bresp, s_axi_rresp, bus_size;
   logic        aclk = 0, aresetn = 0, ack_en = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
   logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, break_req, irq;
   logic        bus_valid, bus_from_dma, bus_fetch, bus_write, cpu_exec_done, break_ack;
   int          fails = 0, num_checks = 0, cyc_cnt = 0;
   logic [31:0] ra [5] = '{`UBK_BA_ADDR_HI, `UBK_BA_ADDR_LO, `UBK_BA_MASK_HI, `UBK_BA_MASK_LO,
                           `UBK_BA_CYC_SEL};
   // Rows: cycle select, bus address, dma fetch write size, expected request
   logic [45:0] rows [14] = '{{8'h65, 32'h123456ab, 6'b000011}, {8'h65, 32'h123457ab, 6'b000010},
      {8'h65, 32'h923456ab, 6'b000010}, {8'h65, 32'h123456ab, 6'b100010},
      {8'h65, 32'h123456ab, 6'b010010}, {8'h65, 32'h123456ab, 6'b001010},
      {8'h65, 32'h123456ab, 6'b000100}, {8'hbf, 32'h12345600, 6'b111111},
      {8'hbf, 32'h12345600, 6'b011110}, {8'hfc, 32'h123456ff, 6'b001101},
      {8'h54, 32'h12345602, 6'b010101}, {8'h3c, 32'h12345600, 6'b000110},
      {8'hcf, 32'h12345600, 6'b000110}, {8'hf3, 32'h12345600, 6'b000110}};
   always #5 aclk = ~aclk;
   ubk_break_unit dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .bus_valid, .bus_addr, .bus_from_dma, .bus_fetch, .bus_write,
      .bus_size, .cpu_exec_done, .cpu_interrupt_mask_level, .break_ack, .break_req,
      .break_level, .irq);
   ubk_far_side fs (.aclk, .break_req, .ack_en, .bus_valid, .bus_addr, .bus_from_dma,
      .bus_fetch, .bus_write, .bus_size, .cpu_exec_done, .break_ack);
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         fails++;
         summarize();
      end
   end
   task wr(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 16'h0000, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
   endtask
   task rd(input logic [31:0] a, input logic [15:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK("rdata", {16'h0000, e}, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask
   task hit(input logic [31:0] a, input logic [4:0] q, input logic e);
      fs.cycle(a, q);
      @(posedge aclk);
      #1 `CHK("break_req", e, break_req)
      while (break_req) @(posedge aclk);
   endtask
   task t_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) rd(ra[i], `UBK_REG_RESET, `UBK_RESP_OKAY);
      rd(32'h00000040, 16'h0000, `UBK_RESP_SLVERR);
      $display("test reset done");
   endtask
   task t_regs;
      for (int i = 0; i < 5; i++) begin
         wr(ra[i], 16'ha5c3 ^ i, 4'hf, `UBK_RESP_OKAY);
         rd(ra[i], (16'ha5c3 ^ i) & (i == 4 ? `UBK_CYC_WMASK : 16'hffff), 0);
      end
      wr(ra[1], 16'h1234, 4'h1, `UBK_RESP_OKAY);
      wr(ra[1], 16'h5600, 4'h2, `UBK_RESP_OKAY);
      rd(ra[1], 16'h5634, `UBK_RESP_OKAY);
      $display("test registers done");
   endtask
   task t_match;
      wr(ra[0], 16'h1234, 4'h3, 0);
      wr(ra[1], 16'h5600, 4'h3, 0);
      wr(ra[2], 16'h0000, 4'h3, 0);
      wr(ra[3], 16'h00ff, 4'h3, 0);
      foreach (rows[i]) begin
         wr(`UBK_BA_CYC_SEL, {8'h00, rows[i][45:38]}, 4'h1, 0);
         hit(rows[i][37:6], rows[i][5:1], rows[i][0]);
      end
      $display("test match done");
   endtask
   task t_defer;
      wr(`UBK_BA_CTRL, 16'h0001, 4'h1, 0);
      // Last match row left read breaks off; CPU fetch read of any size
      wr(`UBK_BA_CYC_SEL, 16'h0054, 4'h1, 0);
      hit(32'h12345602, 5'b01010, 1'b0);
      fs.exec_done();
      @(posedge aclk);
      #1 `CHK("deferred", 1'b1, break_req)
      while (break_req) @(posedge aclk);
      wr(`UBK_BA_CTRL, 16'h0000, 4'h1, 0);
      $display("test defer done");
   endtask
   task t_level;
      @(posedge aclk);
      {ack_en, cpu_interrupt_mask_level} <= {1'b0, 4'hf};
      // Earlier breaks left status set; clear it so irq must come from this hit
      wr(`UBK_BA_INT_STAT, 16'h0003, 4'h1, 0);
      wr(`UBK_BA_INT_MASK, 16'h0001, 4'h1, 0);
      wr(`UBK_BA_CYC_SEL, 16'h0065, 4'h1, 0);
      `CHK("irq idle", 1'b0, irq)
      hit(32'h12345611, 5'b00001, 1'b0);
      `CHK("irq", 1'b1, irq)
      // Second hit while still pending marks the overrun
      hit(32'h12345611, 5'b00001, 1'b0);
      rd(`UBK_BA_INT_STAT, 16'h0003, 0);
      cpu_interrupt_mask_level <= 4'he;
      repeat (2) @(posedge aclk);
      #1 `CHK("released", 1'b1, break_req)
      `CHK("level", `UBK_BREAK_LEVEL, break_level)
      wr(`UBK_BA_INT_STAT, 16'h0001, 4'h1, 0);
      repeat (2) @(posedge aclk);
      #1 `CHK("irq clear", 1'b0, irq)
      @(posedge aclk);
      ack_en <= 1'b1;
      while (break_req) @(posedge aclk);
      $display("test level done");
   endtask
   initial begin
      t_reset();
      t_regs();
      t_reset();
      t_match();
      t_defer();
      t_level();
      summarize();
   end
endmodule // ubk_break_unit_tb
bind ubk_break_unit ubk_break_unit_sva sva_u (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .bus_valid,
   .cpu_exec_done, .cpu_interrupt_mask_level, .break_ack, .break_req, .break_level);
`default_nettype wire
